// >>> dba_pkg.sv
package dba_pkg;

  // Clock and documented one-shot durations
  localparam int unsigned CLK_NS       = 20;
  localparam int unsigned SETTLE_NS    = 150;
  localparam int unsigned CE_NS        = 260;
  localparam int unsigned ACK_NS       = 800;
  localparam int unsigned ADV_NS       = 100;
  localparam int unsigned REF_NS       = 450;
  localparam int unsigned REF_DLY_NS   = 150;
  localparam int unsigned REF_PERIOD_NS = 28000;

  // Least times round up to whole cycles
  localparam logic [5:0]  SETTLE_CYC = 6'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  CE_CYC     = 6'((CE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  ACK_CYC    = 6'((ACK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  ADV_CYC    = 6'((ADV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  REF_CYC    = 6'((REF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0]  REF_DLY_CYC = 6'((REF_DLY_NS + CLK_NS - 1) / CLK_NS);
  // Refresh interval is approximate; rounded down to stay inside the retention budget
  localparam logic [10:0] REF_PERIOD_CYC = 11'(REF_PERIOD_NS / CLK_NS);

  // Register map (byte addresses) and fields
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  STATUS_OFS  = 4'h4;
  localparam logic [3:0]  REFCNT_OFS  = 4'h8;
  localparam int unsigned CTRL_ADV    = 0;
  localparam logic        CTRL_RST    = 1'b0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ALLOW    = 4;
  localparam int unsigned ST_REQ      = 5;
  localparam int unsigned ST_OUTPH    = 6;
  localparam int unsigned ST_REFRESH_ACTIVE_N    = 7;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    DBA_IDLE    = 3'b000,
    DBA_SETTLE  = 3'b001,
    DBA_ADV     = 3'b010,
    DBA_CE      = 3'b011,
    DBA_ACK     = 3'b100,
    DBA_WAIT    = 3'b101,
    DBA_REFRESH = 3'b110
  } dba_state_t;

  // Host pins: addr[0] is the bit-zero lane select, [12:1] cell, [14:13] bank
  typedef struct packed {
    logic        read_strobe_n;
    logic        write_strobe_n;
    logic        board_sel;
    logic        access_block_n;
    logic        init_n;
    logic        byte_high_en_n;
    logic [14:0] addr;
    logic [15:0] data;
  } dba_host_t;

  // Memory array side: odd banks on the high byte
  typedef struct packed {
    logic [5:0]  row;
    logic [5:0]  col;
    logic [7:0]  chip_en_n;
    logic        we_n;
    logic [15:0] wdata;
    logic        to_bus;
    logic        latch_en;
  } dba_mem_t;

endpackage

// >>> dba_ctrl.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Operation
// R01 - Read starts on strobe, select, no refresh
// R02 - Write starts on strobe, select, no refresh
// R03 - Resolver gives refresh priority over access
// R04 - Access starts settle delay, clears refresh allow
// R05 - Settle end opens chip-enable window
// R06 - Read window end latches data, starts ack
// R07 - Acknowledge driven only during ack phase
// R08 - Read ack ends on timeout or strobe rise
// R09 - Write ack ends on timeout or strobe rise
// R10 - Write strobe drives memory write enable
// R11 - Transceiver direction follows read strobe
// R12 - Read strobe enables read data latches
// R13 - Output phase flop picks driven lanes
// R14 - Refresh timer sets request about 28us
// R15 - Request and allow start refresh phase
// R16 - Refresh drives counter as row address
// R17 - Refresh holds column address at zero
// R18 - Refresh blocks strobes, clears request
// R19 - After delay refresh enables every bank
// R20 - Refresh end increments counter, returns idle
// R21 - Bit zero and bank bits decoded one-of-eight
// R22 - Byte-high enable selects odd and even
// R23 - Initialize presets refresh allow
// R24 - Block input stops accesses, not refresh
// R25 - Advance write delays enable and acknowledge
// R26 - One-shots are rounded-up cycle counters
// R27 - Strobes synchronised; refresh wins a tie
module dba_ctrl (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire dba_pkg::dba_host_t host,
  output logic [15:0]             data_o,
  output logic [1:0]              data_oe,
  output logic                    transfer_ack_n_o,
  output logic                    transfer_ack_oe,
  input  wire logic [15:0]        mem_rdata,
  output dba_pkg::dba_mem_t       mem,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [3:0]         s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp
);

  localparam int HW = $bits(dba_pkg::dba_host_t);

  logic [HW-1:0]          s1;
  logic [HW-1:0]          s2;
  logic [HW-1:0]          s3;
  dba_pkg::dba_host_t     pin;
  dba_pkg::dba_state_t    state;
  logic [5:0]             tmr;
  logic [10:0]            ref_tmr;
  logic                   refresh_req;
  logic                   refresh_allow_ff;
  logic                   output_phase_ff;
  logic                   is_read;
  logic                   adv_write;
  logic [5:0]             ref_cnt;
  logic                   refresh_active_n;
  logic                   access_active_n;
  logic                   selected;
  logic                   host_req;
  logic                   ref_go;
  logic                   ref_ce;
  logic                   strobe_up;
  logic                   odd_byte;
  logic [7:0]             decoder_lower_output;
  logic [7:0]             chip_en_n;
  logic                   aw_hold;
  logic                   w_hold;
  logic [3:0]             aw_addr_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;

  // Three-stage pin synchroniser; a bit changes once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < HW; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1[gi]  <= 1'b1;
          s2[gi]  <= 1'b1;
          s3[gi]  <= 1'b1;
          pin[gi] <= 1'b1;
        end else if (clk_en) begin
          s1[gi] <= host[gi]; // R27
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            pin[gi] <= s2[gi];
          end
        end
      end
    end
  endgenerate

  assign refresh_active_n = (state != dba_pkg::DBA_REFRESH);
  assign access_active_n  = !(state inside {dba_pkg::DBA_SETTLE, dba_pkg::DBA_ADV,
                                            dba_pkg::DBA_CE, dba_pkg::DBA_ACK});
  // Inhibit stops the board answering while refresh keeps running
  assign selected  = pin.board_sel && pin.access_block_n; // R24
  assign host_req  = selected && (!pin.read_strobe_n || !pin.write_strobe_n); // R01 R02
  // Refresh is checked first, so a tie in the same cycle goes to refresh
  assign ref_go    = refresh_req && refresh_allow_ff; // R15 R27
  assign ref_ce    = !refresh_active_n && (tmr < (dba_pkg::REF_CYC - dba_pkg::REF_DLY_CYC)); // R19
  assign strobe_up = is_read ? pin.read_strobe_n : pin.write_strobe_n;
  assign odd_byte  = pin.addr[0] && pin.byte_high_en_n;

  // Sequencer: every one-shot but the refresh delay is a down counter loaded with its rounded-up length less one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= dba_pkg::DBA_IDLE;
      tmr     <= 6'h00;
      is_read <= 1'b0;
      ref_cnt <= 6'h00;
    end else if (clk_en) begin
      if (tmr != 6'h00) begin
        tmr <= tmr - 6'h01;
      end
      unique case (state)
        dba_pkg::DBA_IDLE: begin
          if (ref_go) begin
            state <= dba_pkg::DBA_REFRESH; // R03
            tmr   <= dba_pkg::REF_CYC - 6'h01; // R15 R26
          end else if (host_req) begin
            state   <= dba_pkg::DBA_SETTLE; // R01 R02 R03
            tmr     <= dba_pkg::SETTLE_CYC - 6'h01; // R04 R26
            is_read <= !pin.read_strobe_n;
          end
        end
        dba_pkg::DBA_SETTLE: begin
          if (tmr == 6'h00) begin
            if (!is_read && adv_write) begin
              state <= dba_pkg::DBA_ADV; // R25
              tmr   <= dba_pkg::ADV_CYC - 6'h01;
            end else begin
              state <= dba_pkg::DBA_CE; // R05
              tmr   <= dba_pkg::CE_CYC - 6'h01;
            end
          end
        end
        dba_pkg::DBA_ADV: begin
          if (tmr == 6'h00) begin
            state <= dba_pkg::DBA_CE; // R25
            tmr   <= dba_pkg::CE_CYC - 6'h01;
          end
        end
        dba_pkg::DBA_CE: begin
          if (tmr == 6'h00) begin
            state <= dba_pkg::DBA_ACK; // R06
            tmr   <= dba_pkg::ACK_CYC - 6'h01;
          end
        end
        dba_pkg::DBA_ACK: begin
          if (tmr == 6'h00 || strobe_up) begin
            state <= strobe_up ? dba_pkg::DBA_IDLE : dba_pkg::DBA_WAIT; // R08 R09
          end
        end
        dba_pkg::DBA_WAIT: begin
          // A timed-out access waits here for the strobe release, unless a due refresh runs first and then returns to idle
          if (ref_go) begin
            state <= dba_pkg::DBA_REFRESH;
            tmr   <= dba_pkg::REF_CYC - 6'h01;
          end else if (strobe_up) begin
            state <= dba_pkg::DBA_IDLE;
          end
        end
        dba_pkg::DBA_REFRESH: begin
          if (tmr == 6'h00) begin
            state   <= dba_pkg::DBA_IDLE; // R20
            ref_cnt <= ref_cnt + 6'h01; // R20
          end
        end
        default: begin
          state <= dba_pkg::DBA_IDLE;
        end
      endcase
    end
  end

  // Refresh interval timer and request flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_tmr     <= 11'h000;
      refresh_req <= 1'b0;
    end else if (clk_en) begin
      if (ref_tmr == dba_pkg::REF_PERIOD_CYC - 11'h001) begin
        ref_tmr     <= 11'h000;
        refresh_req <= 1'b1; // R14
      end else begin
        ref_tmr <= ref_tmr + 11'h001;
        if (!refresh_active_n) begin
          refresh_req <= 1'b0; // R18
        end
      end
    end
  end

  // Refresh allow: preset by initialize, cleared through an access, set at its end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_allow_ff <= 1'b1;
    end else if (clk_en) begin
      if (!pin.init_n) begin
        refresh_allow_ff <= 1'b1; // R23
      end else if (state == dba_pkg::DBA_ACK && (tmr == 6'h00 || strobe_up)) begin
        refresh_allow_ff <= 1'b1; // R08 R09
      end else if (!access_active_n) begin
        refresh_allow_ff <= 1'b0; // R04
      end
    end
  end

  // Read data latch and output phase flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_o          <= 16'h0000;
      output_phase_ff <= 1'b0;
    end else if (clk_en) begin
      if (state == dba_pkg::DBA_CE && tmr == 6'h00 && is_read && !pin.read_strobe_n) begin
        // An 8-bit host reads the odd bank on the low lane
        data_o          <= {mem_rdata[15:8], odd_byte ? mem_rdata[15:8] : mem_rdata[7:0]}; // R06 R12
        output_phase_ff <= 1'b1; // R13
      end else if (pin.read_strobe_n) begin
        output_phase_ff <= 1'b0;
      end
    end
  end

  assign data_oe[0]       = output_phase_ff && !pin.read_strobe_n &&
                            (!pin.addr[0] || pin.byte_high_en_n); // R13
  assign data_oe[1]       = output_phase_ff && !pin.read_strobe_n && !pin.byte_high_en_n; // R13
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_oe  = (state == dba_pkg::DBA_ACK); // R07

  // Bank decode: even banks on the low outputs, odd banks on the high ones
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bank
      assign decoder_lower_output[gi]   = ({pin.addr[0], pin.addr[14:13]} == 3'(gi)); // R21
      assign decoder_lower_output[gi+4] = ({pin.addr[0], pin.addr[14:13]} == 3'(gi + 4)) ||
                                          (decoder_lower_output[gi] && !pin.byte_high_en_n); // R22
    end
  endgenerate

  // Kept apart from the struct so that the struct has only continuous drivers
  always_comb begin
    chip_en_n = 8'hff;
    if (ref_ce) begin
      chip_en_n = 8'h00; // R19
    end else if (state == dba_pkg::DBA_CE) begin
      chip_en_n = ~decoder_lower_output; // R05
    end
  end

  assign mem.chip_en_n = chip_en_n;
  assign mem.row      = refresh_active_n ? pin.addr[6:1] : ref_cnt; // R16
  assign mem.col      = refresh_active_n ? pin.addr[12:7] : 6'h00; // R17
  assign mem.we_n     = pin.write_strobe_n || !refresh_active_n || !selected; // R10 R18
  assign mem.wdata    = {odd_byte ? pin.data[7:0] : pin.data[15:8], pin.data[7:0]};
  assign mem.to_bus   = !pin.read_strobe_n; // R11
  assign mem.latch_en = !pin.read_strobe_n && is_read; // R12

  // AXI4-Lite slave; address and data are taken in either order
  assign s_axi_awready = clk_en && !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_hold && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr_q    <= 4'h0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dba_pkg::RESP_OKAY;
      adv_write    <= dba_pkg::CTRL_RST;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_hold && w_hold) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= dba_pkg::RESP_OKAY;
        if (aw_addr_q == dba_pkg::CTRL_OFS) begin
          if (w_strb_q[0]) begin
            adv_write <= w_data_q[dba_pkg::CTRL_ADV];
          end
        end else if (aw_addr_q != dba_pkg::STATUS_OFS && aw_addr_q != dba_pkg::REFCNT_OFS) begin
          s_axi_bresp <= dba_pkg::RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dba_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= dba_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        unique case (s_axi_araddr)
          dba_pkg::CTRL_OFS: begin
            s_axi_rdata[dba_pkg::CTRL_ADV] <= adv_write;
          end
          dba_pkg::STATUS_OFS: begin
            s_axi_rdata[dba_pkg::ST_STATE_LSB +: 3] <= state;
            s_axi_rdata[dba_pkg::ST_ALLOW]          <= refresh_allow_ff;
            s_axi_rdata[dba_pkg::ST_REQ]            <= refresh_req;
            s_axi_rdata[dba_pkg::ST_OUTPH]          <= output_phase_ff;
            s_axi_rdata[dba_pkg::ST_REFRESH_ACTIVE_N]          <= !refresh_active_n;
          end
          dba_pkg::REFCNT_OFS: begin
            s_axi_rdata[5:0] <= ref_cnt;
          end
          default: begin
            s_axi_rresp <= dba_pkg::RESP_DECERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Timing checks assume clk_en stays high
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  tie_refresh_a: assert property ((state == dba_pkg::DBA_IDLE && ref_go && host_req)
    |=> state == dba_pkg::DBA_REFRESH) else $error("Refresh lost a tie"); // R03 R27
  settle_len_a: assert property ($rose(state == dba_pkg::DBA_SETTLE)
    |-> (state == dba_pkg::DBA_SETTLE)[*8] ##1 state != dba_pkg::DBA_SETTLE)
    else $error("Settle phase length wrong"); // R04
  allow_clear_a: assert property (state == dba_pkg::DBA_CE |-> !refresh_allow_ff)
    else $error("Refresh allowed during access"); // R04
  ce_window_a: assert property ($rose(state == dba_pkg::DBA_CE)
    |-> (mem.chip_en_n != 8'hff)[*8] ##6 state == dba_pkg::DBA_ACK)
    else $error("Chip enable window wrong"); // R05 R06
  ack_drive_a: assert property ($rose(state == dba_pkg::DBA_ACK)
    |-> transfer_ack_oe && !transfer_ack_n_o && !$past(transfer_ack_oe))
    else $error("Acknowledge not driven"); // R07
  ack_bound_a: assert property (state == dba_pkg::DBA_ACK |-> ##[1:40] state != dba_pkg::DBA_ACK)
    else $error("Acknowledge phase too long"); // R08 R09
  ack_release_a: assert property ((state == dba_pkg::DBA_ACK && strobe_up)
    |=> !transfer_ack_oe && refresh_allow_ff) else $error("Strobe rise did not end ack"); // R08 R09
  ref_all_ce_a: assert property ($rose(!refresh_active_n)
    |-> (mem.chip_en_n == 8'hff)[*8] ##1 mem.chip_en_n == 8'h00)
    else $error("Refresh enable timing wrong"); // R19
  ref_addr_a: assert property (!refresh_active_n |-> mem.col == 6'h00 && mem.row == ref_cnt && mem.we_n)
    else $error("Refresh address or write wrong"); // R16 R17 R18
  ref_step_a: assert property ($fell(!refresh_active_n) |-> ref_cnt == $past(ref_cnt) + 6'h01)
    else $error("Refresh counter not stepped"); // R20

  read_done_c: cover property (state == dba_pkg::DBA_ACK && is_read && strobe_up);
  write_done_c: cover property (state == dba_pkg::DBA_ACK && !is_read && strobe_up);
  refresh_c: cover property ($fell(!refresh_active_n));
  held_off_c: cover property (!refresh_active_n && host_req);

endmodule

// >>> dba_host_bfm.sv
`timescale 1ns/1ns
module dba_host_bfm (
  input  wire logic              aclk,
  input  wire logic              ack_oe,
  input  wire logic [15:0]       data_o,
  input  wire logic [1:0]        data_oe,
  input  wire dba_pkg::dba_mem_t mem,
  output dba_pkg::dba_host_t     host
);
  logic [15:0]       cap_data;
  logic [1:0]        cap_oe;
  dba_pkg::dba_mem_t cap_mem;

  initial host = {6'h3f, 15'h0, 16'h0};

  // Hold keeps the strobe past the ack so the timeout ends it
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] d, input logic byte_high_en_n_n,
                      input logic hold, output int lat, output int alen);
    lat = 0;
    alen = 0;
    host.addr <= a;
    host.data <= d;
    host.byte_high_en_n <= byte_high_en_n_n;
    if (rd) begin
      host.read_strobe_n <= 1'b0;
    end else begin
      host.write_strobe_n <= 1'b0;
    end
    while (!ack_oe && lat < 200) begin
      @(posedge aclk);
      lat++;
    end
    cap_data = data_o;
    cap_oe = data_oe;
    cap_mem = mem;
    if (!hold && ack_oe) begin
      host.read_strobe_n <= 1'b1;
      host.write_strobe_n <= 1'b1;
    end
    while (ack_oe && alen < 100) begin
      @(posedge aclk);
      alen++;
    end
    host.read_strobe_n <= 1'b1;
    host.write_strobe_n <= 1'b1;
    // A released bus must not keep showing the last word
    host.data <= ~d;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// >>> test_dba_board_access_refresh.sv
`timescale 1ns/1ns
module test_dba_board_access_refresh;
  logic               aclk;
  logic               aresetn;
  logic [15:0]        mem_rdata;
  logic [15:0]        data_o;
  logic [1:0]         data_oe;
  logic               ack_oe;
  logic               ack_n;
  dba_pkg::dba_host_t host;
  dba_pkg::dba_mem_t  mem;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]         s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rr;
  int                 n_errors = 0, samples_checked = 0, cyc = 0, ref_len = 0, ref_last, lat, alen, lat0;
  int                 ref_ends[$];
  logic [5:0]         ref_rows[$];
  logic [5:0]         ref_row;
  logic [7:0]         ce_last;

  dba_ctrl dut (.aclk, .aresetn, .clk_en(1'b1), .host, .data_o, .data_oe, .transfer_ack_n_o(ack_n),
    .transfer_ack_oe(ack_oe), .mem_rdata, .mem, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  dba_host_bfm bfm (.aclk, .ack_oe, .data_o, .data_oe, .mem, .host);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    // Ready stays high between transfers; a missing answer counts as a mismatch
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk(s_axi_rvalid, 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Refresh is recognised by every bank enable low at once
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mem.chip_en_n == 8'h00) begin
      ref_len <= ref_len + 1;
      ref_row <= mem.row;
      chk(mem.col, 6'h0);
      chk({mem.we_n, ack_oe}, 2'b10);
    end else if (ref_len != 0) begin
      ref_ends.push_back(cyc);
      ref_rows.push_back(ref_row);
      ref_last <= ref_len;
      ref_len <= 0;
    end
    if (mem.chip_en_n != 8'hff && mem.chip_en_n != 8'h00) ce_last <= mem.chip_en_n;
  end

  task automatic t_regs();
    axi_rd(dba_pkg::CTRL_OFS, rd, rr);
    chk({rr, rd}, 34'h0);
    axi_rd(dba_pkg::STATUS_OFS, rd, rr);
    chk({rd[dba_pkg::ST_ALLOW], rd[2:0]}, 4'b1000);
    axi_wr(dba_pkg::CTRL_OFS, 32'h1, dba_pkg::RESP_OKAY);
    axi_rd(dba_pkg::CTRL_OFS, rd, rr);
    chk(rd[0], 1'b1);
    axi_wr(4'hc, 32'h1, dba_pkg::RESP_DECERR);
    axi_rd(4'hc, rd, rr);
    chk({rr, rd}, {dba_pkg::RESP_DECERR, 32'h0});
    axi_wr(dba_pkg::CTRL_OFS, 32'h0, dba_pkg::RESP_OKAY);
  endtask

  task automatic t_read();
    bfm.xfer(1'b1, {2'b01, 12'h5a5, 1'b0}, 16'h0, 1'b0, 1'b0, lat, alen);
    // Four synchroniser edges, one to decide, one to sample the answer
    chk(lat - dba_pkg::SETTLE_CYC - dba_pkg::CE_CYC, 6);
    chk({bfm.cap_data, bfm.cap_oe, bfm.cap_mem.to_bus, bfm.cap_mem.latch_en}, {16'ha55a, 4'hf});
    chk(ack_n, 1'b0);
    chk(ce_last, 8'hdd);
    chk(alen < 8, 1'b1);
    fork
      bfm.xfer(1'b1, {2'b10, 12'h0, 1'b1}, 16'h0, 1'b1, 1'b1, lat, alen);
      begin
        // Inside the ack phase refresh is locked out until initialize presets it
        repeat (30) @(posedge aclk);
        axi_rd(dba_pkg::STATUS_OFS, rd, rr);
        chk({rd[dba_pkg::ST_ALLOW], rd[2:0]}, 4'b0100);
        bfm.host.init_n <= 1'b0;
        repeat (6) @(posedge aclk);
        axi_rd(dba_pkg::STATUS_OFS, rd, rr);
        chk(rd[dba_pkg::ST_ALLOW], 1'b1);
        bfm.host.init_n <= 1'b1;
      end
    join
    chk({ce_last, bfm.cap_oe}, {8'hbf, 2'b01});
    chk(alen, dba_pkg::ACK_CYC);
  endtask

  task automatic t_write();
    bfm.xfer(1'b0, {2'b11, 12'h0f0, 1'b0}, 16'h3c96, 1'b1, 1'b0, lat0, alen);
    chk({bfm.cap_mem.we_n, bfm.cap_mem.to_bus, bfm.cap_mem.wdata, ce_last}, {2'b00, 16'h3c96, 8'hf7});
    chk(alen < 8, 1'b1);
    chk({bfm.cap_mem.row, bfm.cap_mem.col}, {6'h30, 6'h03});
    axi_wr(dba_pkg::CTRL_OFS, 32'h1, dba_pkg::RESP_OKAY);
    bfm.xfer(1'b0, {2'b11, 12'h0f0, 1'b0}, 16'hc369, 1'b1, 1'b1, lat, alen);
    chk(lat - lat0, dba_pkg::ADV_CYC);
    chk(alen, dba_pkg::ACK_CYC);
    axi_wr(dba_pkg::CTRL_OFS, 32'h0, dba_pkg::RESP_OKAY);
  endtask

  task automatic t_block_refresh();
    int n;
    n = 0;
    bfm.host.board_sel <= 1'b0;
    bfm.xfer(1'b1, 15'h0, 16'h0, 1'b1, 1'b0, lat, alen);
    chk(lat, 200);
    bfm.host.board_sel <= 1'b1;
    bfm.host.access_block_n <= 1'b0;
    bfm.xfer(1'b0, 15'h0, 16'h1, 1'b1, 1'b0, lat, alen);
    chk(lat, 200);
    ref_ends.delete();
    ref_rows.delete();
    // First interval may be stretched by the access before it, so the one between the second and third refresh ends is measured
    while (ref_ends.size() < 3 && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    chk(ref_ends[2] - ref_ends[1], dba_pkg::REF_PERIOD_CYC);
    chk(ref_rows[2], 6'(ref_rows[1] + 6'h1));
    chk(ref_last, dba_pkg::REF_CYC - dba_pkg::REF_DLY_CYC);
    bfm.host.access_block_n <= 1'b1;
  endtask

  initial begin
    aresetn = 1'b0;
    mem_rdata = 16'ha55a;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00f;
    s_axi_wdata = 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_read();
    t_write();
    t_block_refresh();
    conclude();
  end

  initial begin
    #400000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
